// *** rtl/hlt_pkg.sv ***
// Function
// - Each prescaled tick advances the 8-bit count while counting is allowed.
// - Count equal to period signals a match and returns to zero next tick.
// - Device reset clears the count and loads the period with all ones.
// - Count write, control write, reset or external reset clear both scalers.
// - A control write leaves the count value unchanged.
// - Postscaler counts matches; at select value emits one-tick pulse and clears.
// - One-shot match stops timer and clears run enable; restart needs re-enable.
// - One-shot restart resets the postscaler, so only select zero is useful.
// - Monostable edge-start match stops timer but keeps run enable for external restart.
// - Gate modes hold the count while the gate is inactive, then resume.
// - External edge and level triggers are ignored during debug freeze; the free-running gate is not.
// - Free-running 000 software gate, 001 gate high, 010 gate low.
// - Free-running 011/100/101 reset on any, rising, falling external edge.
// - Free-running 110/111 hold count in reset while external low/high.
// - One-shot 000 starts on enable; 001/010/011 start on rise/fall/any edge.
// - One-shot 100/101 start on first edge, reset on later same edges.
// - One-shot 110/111 start on rise/fall edge, reset on low/high level.
// - Monostable 001/010/011 edge start; match stops at zero, enable kept.
// - Group 10 codes 110/111 start on high/low, reset on low/high, one-shot.
// - One-shot: tick after match clears enable and stops count at zero.
// - Edge-started modes need a fresh edge after enable is set again.
// - Edge limit one-shot resumes counting two ticks after each reset edge.
package hlt_pkg;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_MODE = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h4;
  localparam int unsigned CTRL_ON_BIT = 7;
  localparam int unsigned CTRL_CKPS_MSB = 6;
  localparam int unsigned CTRL_CKPS_LSB = 4;
  localparam int unsigned CTRL_POSTSCALE_SELECT_MSB = 3;
  localparam int unsigned CTRL_POSTSCALE_SELECT_LSB = 0;
  localparam int unsigned MODE_MSB = 4;
  localparam int unsigned PRE_W = 7;
  localparam logic [DATA_W-1:0] COUNT_RST = 8'h00;
  localparam logic [DATA_W-1:0] PERIOD_RST = 8'hff;
  localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
  localparam logic [4:0] MODE_RST = 5'h00;
  localparam logic [3:0] POST_RST = 4'h0;
  localparam logic [1:0] GRP_FREE = 2'h0;
  localparam logic [1:0] GRP_ONE = 2'h1;
  localparam logic [1:0] GRP_MONO = 2'h2;
  localparam logic [2:0] LOW_SW = 3'h0;
  localparam logic [2:0] LOW_1 = 3'h1;
  localparam logic [2:0] LOW_2 = 3'h2;
  localparam logic [2:0] LOW_3 = 3'h3;
  localparam logic [2:0] LOW_4 = 3'h4;
  localparam logic [2:0] LOW_5 = 3'h5;
  localparam logic [2:0] LOW_6 = 3'h6;
  localparam logic [2:0] LOW_7 = 3'h7;
  localparam logic [1:0] HOLD_TICKS = 2'h2;
  typedef enum logic [1:0] {PH_IDLE, PH_RUN, PH_HOLD} hlt_phase_t;
endpackage

// *** rtl/hlt_prescaler.sv ***
`timescale 1ns/100ps
module hlt_prescaler
  import hlt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clr,
  input wire logic [2:0] ckps,
  output logic tick
);
  logic [PRE_W-1:0] cnt_q;
  logic [PRE_W-1:0] mask;

  // Bit i of the mask takes part when the ratio is above 2 to the i.
  for (genvar i = 0; i < PRE_W; i++) begin : g_mask
    assign mask[i] = (ckps > 3'(i));
  end

  assign tick = ((cnt_q | ~mask) == {PRE_W{1'b1}});

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (clr) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 7'h01;
    end
  end
endmodule

// *** rtl/hlt_ext_detect.sv ***
`timescale 1ns/100ps
module hlt_ext_detect
  import hlt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic tick,
  input wire logic ext_in,
  output logic rise,
  output logic fall
);
  logic prev_q;

  // The external level is compared once per timer tick.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prev_q <= 1'b0;
    end else if (tick) begin
      prev_q <= ext_in;
    end
  end

  assign rise = tick & ext_in & ~prev_q;
  assign fall = tick & ~ext_in & prev_q;
endmodule

// *** rtl/hlt_timer.sv ***
`timescale 1ns/100ps
module hlt_timer
  import hlt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic ext_reset_signal,
  input wire logic dbg_freeze,
  output logic [DATA_W-1:0] timer_count,
  output logic postscaled_pulse,
  output logic run_enable_bit
);
  logic [DATA_W-1:0] count_q;
  logic [DATA_W-1:0] period_q;
  logic run_enable_q;
  logic [2:0] ckps_q;
  logic [3:0] postscale_select_q;
  logic [4:0] mode_q;
  logic [3:0] post_cnt_q;
  logic pulse_q;
  logic [DATA_W-1:0] rdata_q;
  hlt_phase_t phase_q;
  logic [1:0] hold_q;

  logic tick;
  logic rise_raw;
  logic fall_raw;
  logic rise;
  logic fall;
  logic lvl_hi;
  logic lvl_lo;
  logic [1:0] grp;
  logic [2:0] low;
  logic reserved;
  logic active;
  logic start_c;
  logic hw_rst;
  logic rst_edge;
  logic gate_ok;
  logic counting;
  logic period_hit;
  logic match_ev;
  logic post_hit;
  logic stops_on_match;
  logic clears_on;
  logic restart;
  logic scaler_clr;
  logic wr_count;
  logic wr_period;
  logic wr_ctrl;
  logic wr_mode;

  assign wr_count = reg_wr && (reg_addr == OFS_COUNT);
  assign wr_period = reg_wr && (reg_addr == OFS_PERIOD);
  assign wr_ctrl = reg_wr && (reg_addr == OFS_CONTROL);
  assign wr_mode = reg_wr && (reg_addr == OFS_MODE);

  hlt_prescaler u_pre (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .clr(scaler_clr),
    .ckps(ckps_q),
    .tick(tick)
  );

  hlt_ext_detect u_ext (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .tick(tick),
    .ext_in(ext_reset_signal),
    .rise(rise_raw),
    .fall(fall_raw)
  );

  // Freeze masks every edge and level trigger; the free-running gate still reads the raw external signal.
  assign rise = rise_raw & ~dbg_freeze;
  assign fall = fall_raw & ~dbg_freeze;
  assign lvl_hi = ext_reset_signal & ~dbg_freeze;
  assign lvl_lo = ~ext_reset_signal & ~dbg_freeze;

  assign grp = mode_q[4:3];
  assign low = mode_q[2:0];

  // Unused codes leave the timer halted.
  always_comb begin
    reserved = 1'b0;
    if (grp == GRP_MONO) begin
      reserved = (low == LOW_SW) || (low == LOW_4) || (low == LOW_5);
    end else if (grp != GRP_FREE && grp != GRP_ONE) begin
      reserved = 1'b1;
    end
  end

  assign active = tick && run_enable_q && !reserved;

  // Decode of start, reset and gate conditions for the selected mode.
  always_comb begin
    start_c = 1'b0;
    hw_rst = 1'b0;
    rst_edge = 1'b0;
    gate_ok = 1'b1;
    case (grp)
      GRP_FREE: begin
        case (low)
          LOW_1: gate_ok = ext_reset_signal;
          LOW_2: gate_ok = ~ext_reset_signal;
          LOW_3: hw_rst = rise | fall;
          LOW_4: hw_rst = rise;
          LOW_5: hw_rst = fall;
          LOW_6: hw_rst = lvl_lo;
          LOW_7: hw_rst = lvl_hi;
          default: gate_ok = 1'b1;
        endcase
      end
      GRP_ONE: begin
        case (low)
          LOW_SW: start_c = 1'b1;
          LOW_1: start_c = rise;
          LOW_2: start_c = fall;
          LOW_3: start_c = rise | fall;
          LOW_4: begin
            start_c = rise;
            hw_rst = rise;
            rst_edge = 1'b1;
          end
          LOW_5: begin
            start_c = fall;
            hw_rst = fall;
            rst_edge = 1'b1;
          end
          LOW_6: begin
            start_c = rise;
            hw_rst = lvl_lo;
          end
          LOW_7: begin
            start_c = fall;
            hw_rst = lvl_hi;
          end
          default: start_c = 1'b0;
        endcase
      end
      GRP_MONO: begin
        case (low)
          LOW_1: start_c = rise;
          LOW_2: start_c = fall;
          LOW_3: start_c = rise | fall;
          LOW_6: begin
            start_c = lvl_hi;
            hw_rst = lvl_lo;
          end
          LOW_7: begin
            start_c = lvl_lo;
            hw_rst = lvl_hi;
          end
          default: start_c = 1'b0;
        endcase
      end
      default: start_c = 1'b0;
    endcase
  end

  // The one-shot group and the level codes of group 10 drop the enable on match.
  assign clears_on = (grp == GRP_ONE) ||
                     ((grp == GRP_MONO) && (low[2:1] == 2'b11));
  assign stops_on_match = (grp != GRP_FREE);

  // Free-running modes count on enable and gate; the others after a start.
  assign counting = (grp == GRP_FREE) ? gate_ok : (phase_q == PH_RUN);
  assign period_hit = (count_q == period_q);
  assign match_ev = active && counting && !hw_rst && period_hit;
  assign post_hit = (post_cnt_q == postscale_select_q);

  // A start out of idle in a one-shot group is a restart.
  assign restart = active && (grp == GRP_ONE) && (phase_q == PH_IDLE) && start_c;

  assign scaler_clr = wr_count || wr_ctrl || (active && hw_rst) || restart;

  // Timer count.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      count_q <= COUNT_RST;
    end else if (wr_count) begin
      count_q <= reg_wdata;
    end else if (active) begin
      if (hw_rst && (grp == GRP_FREE || phase_q != PH_IDLE)) begin
        count_q <= COUNT_RST;
      end else if (counting) begin
        if (period_hit) begin
          count_q <= COUNT_RST;
        end else begin
          count_q <= count_q + 8'h01;
        end
      end
    end
  end

  // Period value.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      period_q <= PERIOD_RST;
    end else if (wr_period) begin
      period_q <= reg_wdata;
    end
  end

  // Control fields; a control write never touches the count.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ckps_q <= CTRL_RST[CTRL_CKPS_MSB:CTRL_CKPS_LSB];
      postscale_select_q <= CTRL_RST[CTRL_POSTSCALE_SELECT_MSB:CTRL_POSTSCALE_SELECT_LSB];
    end else if (wr_ctrl) begin
      ckps_q <= reg_wdata[CTRL_CKPS_MSB:CTRL_CKPS_LSB];
      postscale_select_q <= reg_wdata[CTRL_POSTSCALE_SELECT_MSB:CTRL_POSTSCALE_SELECT_LSB];
    end
  end

  // Run enable: software writes win over the match clear in the same cycle.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      run_enable_q <= CTRL_RST[CTRL_ON_BIT];
    end else if (wr_ctrl) begin
      run_enable_q <= reg_wdata[CTRL_ON_BIT];
    end else if (match_ev && clears_on) begin
      run_enable_q <= 1'b0;
    end
  end

  // Mode select.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mode_q <= MODE_RST;
    end else if (wr_mode) begin
      mode_q <= reg_wdata[MODE_MSB:0];
    end
  end

  // Start phase for the non-free groups.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      phase_q <= PH_IDLE;
      hold_q <= '0;
    end else if (!run_enable_q) begin
      phase_q <= PH_IDLE;
      hold_q <= '0;
    end else if (active && grp != GRP_FREE) begin
      case (phase_q)
        PH_IDLE: begin
          if (start_c) begin
            phase_q <= PH_RUN;
          end
        end
        PH_RUN: begin
          if (hw_rst && rst_edge) begin
            phase_q <= PH_HOLD;
            hold_q <= HOLD_TICKS - 2'h1;
          end else if (match_ev && stops_on_match) begin
            phase_q <= PH_IDLE;
          end
        end
        PH_HOLD: begin
          if (hw_rst && rst_edge) begin
            hold_q <= HOLD_TICKS - 2'h1;
          end else if (hold_q <= 2'h1) begin
            phase_q <= PH_RUN;
            hold_q <= '0;
          end else begin
            hold_q <= hold_q - 2'h1;
          end
        end
        default: phase_q <= PH_IDLE;
      endcase
    end
  end

  // Postscaler counter.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      post_cnt_q <= POST_RST;
    end else if (scaler_clr) begin
      post_cnt_q <= POST_RST;
    end else if (match_ev) begin
      if (post_hit) begin
        post_cnt_q <= POST_RST;
      end else begin
        post_cnt_q <= post_cnt_q + 4'h1;
      end
    end
  end

  // Postscaled output stands from one tick to the next.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pulse_q <= 1'b0;
    end else if (match_ev && post_hit) begin
      pulse_q <= 1'b1;
    end else if (tick || scaler_clr) begin
      pulse_q <= 1'b0;
    end
  end

  // Register read port, data one cycle after the strobe.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_COUNT: rdata_q <= count_q;
        OFS_PERIOD: rdata_q <= period_q;
        OFS_CONTROL: rdata_q <= {run_enable_q, ckps_q, postscale_select_q};
        OFS_MODE: rdata_q <= {3'h0, mode_q};
        OFS_STATUS: rdata_q <= {post_cnt_q, 2'h0, phase_q};
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata = rdata_q;
  assign timer_count = count_q;
  assign postscaled_pulse = pulse_q;
  assign run_enable_bit = run_enable_q;
endmodule

// *** test/hlt_ext_src.sv ***
`timescale 1ns/100ps
module hlt_ext_src (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic want,
  output logic ext_reset_signal
);
  logic [2:0] gap_q;
  // Level changes are held apart by at least seven fastest ticks.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ext_reset_signal <= 1'b0;
      gap_q <= 3'h0;
    end else if (want != ext_reset_signal && gap_q == 3'h6) begin
      ext_reset_signal <= want;
      gap_q <= 3'h0;
    end else if (gap_q != 3'h6) begin
      gap_q <= gap_q + 3'h1;
    end
  end
endmodule

// *** test/hlt_timer_asserts.sv ***
`timescale 1ns/100ps
module hlt_timer_asserts
  import hlt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic ext_reset_signal,
  input wire logic dbg_freeze,
  input wire logic [DATA_W-1:0] timer_count,
  input wire logic postscaled_pulse,
  input wire logic run_enable_bit
);
  logic [DATA_W-1:0] per_q;
  logic [4:0] mode_q;
  logic rsv;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      per_q <= PERIOD_RST;
    end else if (reg_wr && reg_addr == OFS_PERIOD) begin
      per_q <= reg_wdata;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mode_q <= MODE_RST;
    end else if (reg_wr && reg_addr == OFS_MODE) begin
      mode_q <= reg_wdata[4:0];
    end
  end
  assign rsv = (mode_q[4:3] == 2'h3) || (mode_q[4:3] == GRP_MONO &&
    (mode_q[2:0] == LOW_SW || mode_q[2:0] == LOW_4 || mode_q[2:0] == LOW_5));
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_hw_step;
    !$past(reg_wr) ##0 $changed(timer_count);
  endsequence
  sequence s_match_step;
    s_hw_step ##0 $past(timer_count) == $past(per_q);
  endsequence
  a_reset_state: assert property ($rose(rstn) |-> timer_count == COUNT_RST && !run_enable_bit)
    else $error("state after reset wrong");
  a_count_step: assert property (s_hw_step |->
    timer_count == $past(timer_count) + 8'h01 || timer_count == 8'h00)
    else $error("count moved by other than one");
  a_wrap_match: assert property (s_match_step |-> timer_count == 8'h00)
    else $error("count did not wrap at period");
  a_pulse_at_wrap: assert property ($rose(postscaled_pulse) |-> timer_count == 8'h00)
    else $error("pulse without wrap");
  a_pulse_one_tick: assert property (postscaled_pulse && $past(postscaled_pulse) |->
    $stable(timer_count))
    else $error("pulse longer than one tick");
  a_off_frozen: assert property ($past(!run_enable_bit) && !$past(reg_wr) |->
    $stable(timer_count))
    else $error("count moved while disabled");
  a_stop_at_zero: assert property ($fell(run_enable_bit) && !$past(reg_wr) |->
    timer_count == 8'h00)
    else $error("one-shot stop not at zero");
  a_reserved_hold: assert property ($past(rsv) && !$past(reg_wr) |-> $stable(timer_count))
    else $error("count moved in reserved mode");
endmodule
bind hlt_timer hlt_timer_asserts u_asserts (.clk_sys(clk_sys), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .ext_reset_signal(ext_reset_signal), .dbg_freeze(dbg_freeze),
  .timer_count(timer_count), .postscaled_pulse(postscaled_pulse),
  .run_enable_bit(run_enable_bit));

// *** test/hlt_timer_tb.sv ***
`timescale 1ns/100ps
module hlt_timer_tb;
  import hlt_pkg::*;
  logic clk_sys, rstn, reg_wr, reg_rd, want, ext_reset_signal, dbg_freeze;
  logic postscaled_pulse, run_enable_bit, last_p, moved;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, timer_count;
  int fails, total_checks, n_pulse;
  hlt_timer dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_reset_signal(ext_reset_signal), .dbg_freeze(dbg_freeze), .timer_count(timer_count),
    .postscaled_pulse(postscaled_pulse), .run_enable_bit(run_enable_bit));
  hlt_ext_src u_src (.clk_sys(clk_sys), .rstn(rstn), .want(want),
    .ext_reset_signal(ext_reset_signal));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (postscaled_pulse === 1'b1 && last_p !== 1'b1) n_pulse++;
    if (timer_count !== 8'h00) moved = 1'b1;
    last_p = postscaled_pulse;
  end
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic ext(input logic v);
    @(posedge clk_sys);
    want <= v;
    cyc(8);
  endtask
  task automatic setup(input logic [4:0] m, input logic [7:0] p, input logic [7:0] c);
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_PERIOD, p);
    wr(OFS_COUNT, 8'h00);
    wr(OFS_MODE, {3'h0, m});
    moved = 1'b0;
    wr(OFS_CONTROL, c);
  endtask
  task automatic t_regs;
    logic [DATA_W-1:0] v;
    rd(OFS_COUNT, v);
    chk(v, COUNT_RST);
    rd(OFS_PERIOD, v);
    chk(v, PERIOD_RST);
    rd(3'h7, v);
    chk(v, 8'h00);
  endtask
  task automatic t_scale;
    logic [7:0] c [4] = '{8'h80, 8'h81, 8'h83, 8'h90};
    int span;
    for (int i = 0; i < 4; i++) begin
      span = 3 * (c[i][3:0] + 1) * (1 << c[i][6:4]);
      setup(5'h00, 8'h02, c[i]);
      cyc(2 * span);
      n_pulse = 0;
      cyc(4 * span);
      chk(n_pulse[7:0], 8'h04);
    end
  endtask
  task automatic t_ctrl;
    logic [DATA_W-1:0] v;
    setup(5'h00, 8'h02, 8'h83);
    cyc(5);
    wr(OFS_CONTROL, 8'h03);
    rd(OFS_STATUS, v);
    chk(v & 8'hf0, 8'h00);
    wr(OFS_COUNT, 8'h05);
    wr(OFS_CONTROL, 8'h00);
    rd(OFS_COUNT, v);
    chk(v, 8'h05);
  endtask
  task automatic t_gate;
    logic [DATA_W-1:0] h;
    for (int m = 1; m < 3; m++) begin
      ext(m == 2);
      setup(m[4:0], 8'hff, 8'h80);
      cyc(6);
      chk(moved, 1'b0);
      ext(m == 1);
      ext(m == 2);
      h = timer_count;
      chk(h > 8'h00, 1'b1);
      cyc(6);
      chk(timer_count, h);
      ext(m == 1);
      chk(timer_count > h, 1'b1);
    end
  endtask
  task automatic t_edge;
    int mv;
    for (int m = 3; m < 7; m++) begin
      mv = (m == 6) ? 4 : m;
      @(posedge clk_sys);
      dbg_freeze <= (m == 6);
      ext(1'b0);
      setup(mv[4:0], 8'hff, 8'h80);
      cyc(20);
      ext(1'b1);
      chk(timer_count < 8'h0a, m != 5 && m != 6);
      cyc(12);
      ext(1'b0);
      chk(timer_count < 8'h0a, m == 3 || m == 5);
    end
    @(posedge clk_sys);
    dbg_freeze <= 1'b0;
  endtask
  task automatic t_level;
    for (int m = 6; m < 8; m++) begin
      ext(m == 7);
      setup(m[4:0], 8'hff, 8'h80);
      cyc(10);
      chk(moved, 1'b0);
      ext(m == 6);
      chk(moved, 1'b1);
    end
  endtask
  task automatic wait_off;
    for (int i = 0; i < 40 && run_enable_bit !== 1'b0; i++) cyc(1);
  endtask
  task automatic t_oneshot;
    ext(1'b0);
    setup(5'h08, 8'h03, 8'h80);
    n_pulse = 0;
    wait_off;
    chk(moved, 1'b1);
    chk(run_enable_bit, 1'b0);
    chk(timer_count, 8'h00);
    moved = 1'b0;
    cyc(8);
    chk(moved, 1'b0);
    chk(n_pulse[7:0], 8'h01);
  endtask
  task automatic t_estart;
    for (int m = 9; m < 12; m++) begin
      ext(m == 10);
      setup(m[4:0], 8'h03, 8'h80);
      cyc(6);
      chk(moved, 1'b0);
      ext(m != 10);
      chk(moved, 1'b1);
      chk(run_enable_bit, 1'b0);
      moved = 1'b0;
      wr(OFS_CONTROL, 8'h80);
      cyc(8);
      chk(moved, 1'b0);
    end
  endtask
  task automatic t_mono;
    ext(1'b0);
    setup(5'h11, 8'h03, 8'h80);
    ext(1'b1);
    chk(moved, 1'b1);
    chk(run_enable_bit, 1'b1);
    chk(timer_count, 8'h00);
    moved = 1'b0;
    ext(1'b0);
    chk(moved, 1'b0);
    ext(1'b1);
    chk(moved, 1'b1);
  endtask
  task automatic t_limit;
    ext(1'b0);
    setup(5'h0c, 8'hff, 8'h80);
    cyc(6);
    chk(moved, 1'b0);
    ext(1'b1);
    cyc(20);
    ext(1'b0);
    ext(1'b1);
    chk(timer_count < 8'h0a && timer_count > 8'h00, 1'b1);
  endtask
  task automatic t_lvlshot;
    logic [4:0] r [2] = '{5'h0e, 5'h16};
    for (int i = 0; i < 2; i++) begin
      ext(1'b0);
      setup(r[i], 8'h10, 8'h80);
      cyc(6);
      chk(moved, 1'b0);
      ext(1'b1);
      chk(moved, 1'b1);
      ext(1'b0);
      chk(timer_count, 8'h00);
      ext(1'b1);
      cyc(20);
      chk(run_enable_bit, 1'b0);
    end
  endtask
  task automatic t_reserved;
    logic [4:0] r [4] = '{5'h10, 5'h14, 5'h15, 5'h18};
    for (int i = 0; i < 4; i++) begin
      setup(r[i], 8'hff, 8'h80);
      cyc(10);
      chk(moved, 1'b0);
    end
  endtask
  task automatic results;
    if (fails == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    {rstn, reg_wr, reg_rd, want, dbg_freeze, last_p, moved} = 7'h00;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    fails = 0;
    total_checks = 0;
    n_pulse = 0;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    t_regs;
    t_scale;
    t_ctrl;
    t_gate;
    t_edge;
    t_level;
    t_oneshot;
    t_estart;
    t_mono;
    t_limit;
    t_lvlshot;
    t_reserved;
    results;
  end
  initial begin
    #400000;
    fails++;
    results;
  end
endmodule
